// file: logic/subtract_w_datapath.sv
/*
 * Subtract datapath for the literal and file-register subtract
 * instructions, one instruction per enabled clock.
 * Assumes the file register contents arrive on file_rdata in the same
 * cycle as the address, and that the file write is taken on file_we.
 */
`timescale 1ns/100ps
// What this block does
// - File subtract gives addressed register minus accumulator, two's complement.
// - Destination bit 0 writes the accumulator, 1 writes the file register.
// - Access bit clear uses access bank; set uses bank select pointer.
// - Operands decode as 8-bit address, destination bit and access bit.
// - Negative underflow clears carry; else carry is set. Negative copies result bit 7.
module subtract_w_datapath (
    input  wire logic                           core_clk,
    input  wire logic                           nrst,
    input  wire logic                           insn_valid,
    input  wire logic [sub_pkg::INSN_W-1:0]     insn,
    input  wire logic [sub_pkg::BANK_W-1:0]     bank_select_pointer,
    output logic      [sub_pkg::FILE_ADR_W-1:0] file_addr,
    input  wire logic [sub_pkg::DATA_W-1:0]     file_rdata,
    output logic                                file_we,
    output logic      [sub_pkg::DATA_W-1:0]     file_wdata,
    output logic      [sub_pkg::DATA_W-1:0]     acc,
    output logic                                carry_flag,
    output logic                                digit_carry_flag,
    output logic                                zero_flag,
    output logic                                overflow_flag,
    output logic                                negative_flag,
    output logic                                insn_done
);
    import sub_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] acc;
        logic [4:0]        flags;
        logic              we;
        logic [DATA_W-1:0] wdata;
        logic              done;
    } state_s;

    state_s state;
    state_s next_state;
    logic              is_lit;
    logic              is_file;
    logic              dest_file;
    logic              access_bsr;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] minuend;
    logic [DATA_W-1:0] diff;
    logic [FLAG_W-1:0] core_flags;
    logic              srst_n;
    logic [1:0]        rst_sync;

    // Opcode match on the top byte
    function automatic logic op_is_lit(input logic [INSN_W-1:0] word);
        return word[15:8] == OPC_LIT;
    endfunction

    // Opcode match on the top six bits
    function automatic logic op_is_file(input logic [INSN_W-1:0] word);
        return word[15:10] == OPC_FILE;
    endfunction

    // Access bank split keeps low addresses in bank 0
    function automatic logic [FILE_ADR_W-1:0] map_addr(
        input logic              banked,
        input logic [BANK_W-1:0] bank,
        input logic [ADDR_W-1:0] addr
    );
        logic [FILE_ADR_W-1:0] full;
        if (banked) begin
            full = {bank, addr};
        end else if (addr < ACC_SPLIT) begin
            full = {ACC_LO_BANK, addr};
        end else begin
            full = {ACC_HI_BANK, addr};
        end
        return full;
    endfunction

    // Reset release through two flops; async assert
    // Kept apart from the state struct: it is the only async-on-pin flop
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign srst_n = rst_sync[1];

    always_comb begin
        is_lit     = op_is_lit(insn);
        is_file    = op_is_file(insn);
        dest_file  = insn[POS_D];
        access_bsr = insn[POS_A];
        reg_addr   = insn[ADDR_W-1:0];
        // Access bank: addresses below 0x60 to bank 0, the rest to bank F
        file_addr  = map_addr(access_bsr, bank_select_pointer,
                              reg_addr);
        minuend = is_lit ? insn[DATA_W-1:0] : file_rdata;
    end

    sub_core u_core (
        .minuend    (minuend),
        .subtrahend (state.acc),
        .diff       (diff),
        .flags      (core_flags)
    );

    always_comb begin
        next_state          = state;
        next_state.we       = 1'b0;
        next_state.done     = 1'b0;
        if (insn_valid && (is_lit || is_file)) begin
            // Carry is not-borrow: clear only on negative underflow
            next_state.flags = core_flags[4:0];
            next_state.done  = 1'b1;
            if (is_file && dest_file) begin
                next_state.we    = 1'b1;
                next_state.wdata = diff;
            end else begin
                next_state.acc = diff;
            end
        end
    end

    always_ff @(posedge core_clk or negedge srst_n) begin
        if (!srst_n) begin
            state.acc   <= ACC_RESET;
            state.flags <= FLAGS_RESET;
            state.we    <= 1'b0;
            state.wdata <= 8'h00;
            state.done  <= 1'b0;
        end else begin
            state.acc   <= next_state.acc;
            state.flags <= next_state.flags;
            state.we    <= next_state.we;
            state.wdata <= next_state.wdata;
            state.done  <= next_state.done;
        end
    end

    assign acc              = state.acc;
    assign file_we          = state.we;
    assign file_wdata       = state.wdata;
    assign carry_flag       = state.flags[FLAG_C];
    assign digit_carry_flag = state.flags[FLAG_DC];
    assign zero_flag        = state.flags[FLAG_Z];
    assign overflow_flag    = state.flags[FLAG_OV];
    assign negative_flag    = state.flags[FLAG_N];
    assign insn_done        = state.done;
endmodule // subtract_w_datapath

// file: common/sub_pkg.sv
/*
 * Constants for the subtract datapath: operand widths, flag positions,
 * opcode fields and reset values.
 * Assumes an 8-bit core with a 16-bit instruction word.
 */
package sub_pkg;
    localparam int DATA_W     = 8;
    localparam int ADDR_W     = 8;
    localparam int BANK_W     = 4;
    localparam int FILE_ADR_W = 12;
    localparam int INSN_W     = 16;
    // Flag vector positions
    localparam int FLAG_C     = 0;
    localparam int FLAG_DC    = 1;
    localparam int FLAG_Z     = 2;
    localparam int FLAG_OV    = 3;
    localparam int FLAG_N     = 4;
    localparam int FLAG_W     = 5;
    // Instruction fields
    localparam int POS_D      = 9;
    localparam int POS_A      = 8;
    localparam logic [7:0] OPC_LIT  = 8'h08;
    localparam logic [5:0] OPC_FILE = 6'h17;
    // Access bank split: low addresses map to bank 0, the rest to bank F
    localparam logic [7:0] ACC_SPLIT = 8'h60;
    localparam logic [3:0] ACC_HI_BANK = 4'hF;
    localparam logic [3:0] ACC_LO_BANK = 4'h0;
    localparam logic [7:0] ACC_RESET   = 8'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
endpackage

// file: logic/sub_core.sv
/*
 * Core of the subtract datapath: 8-bit a minus b with all five flags.
 * Assumes purely combinational use by the datapath above it.
 */
`timescale 1ns/100ps
module sub_core (
    input  wire logic [sub_pkg::DATA_W-1:0] minuend,
    input  wire logic [sub_pkg::DATA_W-1:0] subtrahend,
    output logic      [sub_pkg::DATA_W-1:0] diff,
    output logic      [sub_pkg::FLAG_W-1:0] flags
);
    import sub_pkg::*;
    logic [DATA_W:0] wide;
    logic [4:0]      low;
    always_comb begin
        // Two's complement: a + ~b + 1, carry out is not-borrow
        wide = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
        low  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
        diff = wide[DATA_W-1:0];
        flags = '0;
        flags[FLAG_C]  = wide[DATA_W];
        flags[FLAG_DC] = low[4];
        flags[FLAG_Z]  = (wide[DATA_W-1:0] == 8'h00);
        flags[FLAG_N]  = wide[DATA_W-1];
        flags[FLAG_OV] = (minuend[DATA_W-1] != subtrahend[DATA_W-1])
                      && (wide[DATA_W-1] != minuend[DATA_W-1]);
    end
endmodule // sub_core

// file: verification/sub_monitor.sv
/* Checker on the subtract datapath ports.
   Assumes insn_valid stays low until the reset copy is released. */
`timescale 1ns/100ps
module sub_monitor
    import sub_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        insn_valid,
    input wire logic [15:0] insn,
    input wire logic [3:0]  bank_select_pointer,
    input wire logic [11:0] file_addr,
    input wire logic [7:0]  file_rdata,
    input wire logic        file_we,
    input wire logic [7:0]  file_wdata,
    input wire logic [7:0]  acc,
    input wire logic        carry_flag,
    input wire logic        zero_flag,
    input wire logic        negative_flag,
    input wire logic        insn_done
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    wire       lit = insn[15:8] == OPC_LIT;
    wire       fil = insn[15:10] == OPC_FILE;
    wire [7:0] mnd = lit ? insn[7:0] : file_rdata;
    wire [7:0] dif = mnd - acc;
    wire       nb  = mnd >= acc;
    wire       zr  = dif == 8'h00;
    sequence s_sub; insn_valid && (lit || fil); endsequence
    sequence s_fw; s_sub ##0 fil && insn[POS_D]; endsequence
    property p_lit; insn_valid && lit |=> acc == $past(dif) && insn_done; endproperty
    a_lit: assert property (p_lit) else $error("literal result wrong");
    property p_wr; s_fw |=> file_we && file_wdata == $past(dif) && $stable(acc); endproperty
    a_wr: assert property (p_wr) else $error("file write wrong");
    property p_wa; s_sub ##0 fil && !insn[POS_D] |=> !file_we && acc == $past(dif); endproperty
    a_wa: assert property (p_wa) else $error("acc result wrong");
    property p_bsr; fil && insn[POS_A] |-> file_addr == {bank_select_pointer, insn[7:0]}; endproperty
    a_bsr: assert property (p_bsr) else $error("banked address wrong");
    property p_acb; fil && !insn[POS_A] |-> file_addr == {(insn[7:0] < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK, insn[7:0]}; endproperty
    a_acb: assert property (p_acb) else $error("access address wrong");
    property p_flg; s_sub |=> carry_flag == $past(nb) && zero_flag == $past(zr) && negative_flag == $past(dif[7]); endproperty
    a_flg: assert property (p_flg) else $error("flags wrong");
    property p_ref; !(insn_valid && (lit || fil)) |=> !insn_done; endproperty
    a_ref: assert property (p_ref) else $error("done without subtract");
endmodule // sub_monitor
bind subtract_w_datapath sub_monitor sub_monitor_inst (.core_clk, .nrst, .insn_valid, .insn, .bank_select_pointer, .file_addr, .file_rdata, .file_we, .file_wdata, .acc, .carry_flag, .zero_flag, .negative_flag, .insn_done);

// file: verification/tb.sv
/* Self-checking bench for the subtract datapath.
   Assumes one clock; expectations come from the bench's own model. */
`timescale 1ns/100ps
module tb;
    import sub_pkg::*;
    logic        core_clk = 0, nrst = 0, insn_valid = 0, file_we, insn_done;
    logic        carry_flag, digit_carry_flag, zero_flag, overflow_flag, negative_flag;
    logic [15:0] insn = 16'h0000;
    logic [3:0]  bank_select_pointer = 4'h0;
    logic [11:0] file_addr;
    logic [7:0]  file_rdata = 8'h00, file_wdata, acc, m, d, wacc = 8'h00;
    logic [31:0] seed = 14, r;
    logic [21:0] expq[$];
    int          fails = 0, checks_done = 0;
    wire  [21:0] seen = {file_we, file_we ? file_wdata : 8'h00, acc, carry_flag,
                         digit_carry_flag, zero_flag, overflow_flag, negative_flag};
    always #5 core_clk = ~core_clk;
    subtract_w_datapath subtract_w_datapath_inst (.core_clk, .nrst, .insn_valid, .insn, .bank_select_pointer, .file_addr, .file_rdata, .file_we, .file_wdata, .acc, .carry_flag, .digit_carry_flag, .zero_flag, .overflow_flag, .negative_flag, .insn_done);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [21:0] s, e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic conclude();
        if (fails == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Model runs ahead: back-to-back ops chain through wacc
    task automatic issue(input logic v, input logic [15:0] i, input logic [7:0] f);
        logic wr;
        @(posedge core_clk);
        insn_valid <= v;
        insn <= i;
        file_rdata <= f;
        bank_select_pointer <= f[7:4];
        if (v && (i[15:8] == OPC_LIT || i[15:10] == OPC_FILE)) begin
            m = (i[15:8] == OPC_LIT) ? i[7:0] : f;
            d = m - wacc;
            wr = i[15:10] == OPC_FILE && i[POS_D];
            expq.push_back({wr, wr ? d : 8'h00, wr ? wacc : d, m >= wacc, m[3:0] >= wacc[3:0], d == 8'h00, m[7] != wacc[7] && d[7] != m[7], d[7]});
            if (!wr) wacc = d;
        end
    endtask
    // Sample on the falling edge, away from the launching edge
    always @(negedge core_clk)
        if (insn_done === 1'b1) begin
            if (expq.size() == 0) check(22'h3FFFFF, 22'h000000);
            else check(seen, expq.pop_front());
        end
    initial begin
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        issue(1'b1, 16'h0802, 8'h00);
        issue(1'b1, 16'h0802, 8'h00);
        issue(1'b1, 16'h0800, 8'h00);
        issue(1'b1, 16'h5E10, 8'h03);
        issue(1'b1, 16'h0000, 8'h00);
        for (int k = 0; k < 400; k++) begin
            r = xs();
            case (r[1:0])
                2'd0: issue(1'b1, {OPC_LIT, r[15:8]}, r[23:16]);
                2'd1: issue(1'b1, {OPC_FILE, r[13:4]}, r[23:16]);
                2'd2: issue(1'b1, {2'b11, r[15:2]}, r[23:16]);
                default: issue(1'b0, {OPC_FILE, r[13:4]}, r[23:16]);
            endcase
        end
        issue(1'b0, 16'h0000, 8'h00);
        for (int k = 0; k < 8 && expq.size() > 0; k++) @(posedge core_clk);
        if (expq.size() > 0) fails++;
        conclude();
    end
endmodule // tb
